// File: core/csbd_exec.v
// Execution of compare-skip-if-less and decimal-adjust on a four-quarter cycle
`timescale 1ns/100ps
`include "csbd_defines.vh"

module csbd_exec (
    input  wire        MCLK,          // Core clock, one quarter per rising edge
    input  wire        RST_N,         // Asynchronous reset, active low
    input  wire [15:0] INSTR,         // Fetched instruction word, sampled at Q1
    input  wire        NEXT_TWO_WORD, // Following fetched instruction is two words
    input  wire [7:0]  W_IN,          // Working register contents
    input  wire [7:0]  FILE_DATA,     // Data memory read data, valid at Q3
    input  wire [3:0]  BANK_SEL,      // Bank select register contents
    input  wire        C_IN,          // Carry flag
    input  wire        DC_IN,         // Digit carry flag
    output reg  [1:0]  Q_PHASE,       // Current quarter cycle
    output reg         CYCLE_END,     // Pulse in the last quarter of each cycle
    output reg  [11:0] FILE_ADDR,     // Resolved data memory address
    output reg         FILE_RD,       // Data memory read strobe
    output reg  [7:0]  W_OUT,         // New working register value
    output reg         W_WE,          // Working register write strobe
    output reg         C_OUT,         // New carry flag
    output reg         C_WE,          // Carry flag write strobe
    output reg         FLUSH_NOP,     // Current cycle executes a forced no-operation
    output reg         CMP_LESS       // Last compare found file byte below working register
);

    localparam ST_Q1 = `CSBD_Q1;
    localparam ST_Q2 = `CSBD_Q2;
    localparam ST_Q3 = `CSBD_Q3;
    localparam ST_Q4 = `CSBD_Q4;

    reg [1:0]  q;
    reg [15:0] ir;
    reg        nop_cycle;
    reg [1:0]  flush_cnt;
    reg        less;
    reg [7:0]  daw_value;
    reg        daw_carry;

    reg [1:0]  next_q;
    reg [11:0] next_addr;
    reg [8:0]  diff;
    reg [1:0]  next_flush;

    wire       is_cmp_lt;
    wire       is_daw;
    wire [7:0] bcd_value;
    wire       bcd_carry;

    // Quarter qualifiers
    wire       at_q1;
    wire       at_q2;
    wire       at_q3;
    wire       at_q4;
    wire       flushing;
    wire       skip_taken;

    assign is_cmp_lt = ((ir & `CSBD_CMP_LT_MASK) == `CSBD_CMP_LT_OPC) && !nop_cycle;
    assign is_daw    = (ir == `CSBD_DAW_OPC) && !nop_cycle;

    // Quarter decodes shared by the execution paths
    assign at_q1      = (q == ST_Q1);
    assign at_q2      = (q == ST_Q2);
    assign at_q3      = (q == ST_Q3);
    assign at_q4      = (q == ST_Q4);
    assign flushing   = (flush_cnt != 2'h0);
    // A flushed compare never decodes, so it cannot start a new skip
    assign skip_taken = is_cmp_lt && less;

    csbd_bcd_adjust u_bcd (
        .w_in      (W_IN),
        .carry_in  (C_IN),
        .dcarry_in (DC_IN),
        .w_out     (bcd_value),
        .carry_out (bcd_carry)
    );

    // Quarter sequencing
    always @* begin
        case (q)
            ST_Q1:   next_q = ST_Q2;
            ST_Q2:   next_q = ST_Q3;
            ST_Q3:   next_q = ST_Q4;
            ST_Q4:   next_q = ST_Q1;
            default: next_q = ST_Q1;
        endcase
    end

    // File operand address
    always @* begin
        if (!ir[`CSBD_BANK_BIT]) begin
            if (ir[7:0] < `CSBD_ACCESS_SPLIT) begin
                next_addr = {`CSBD_ACCESS_LOW, ir[7:0]};                                // [RQ3]
            end else begin
                next_addr = {`CSBD_ACCESS_HIGH, ir[7:0]};                               // [RQ3]
            end
        end else begin
            next_addr = {BANK_SEL, ir[7:0]};                                            // [RQ3]
        end
    end

    // Unsigned subtraction: borrow means file byte below working register
    always @* begin
        diff = {1'b0, FILE_DATA} - {1'b0, W_IN};                                        // [RQ1]
    end

    // Quarter counter; the phase outputs mirror it from the same edge
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            q         <= ST_Q1;
            Q_PHASE   <= ST_Q1;
            CYCLE_END <= 1'b0;
        end else begin
            q         <= next_q;
            Q_PHASE   <= next_q;
            CYCLE_END <= (next_q == ST_Q4);
        end
    end

    // Fetch at Q1; a flushed cycle keeps the old word but blocks its decode
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ir        <= `CSBD_RST_INSTR;
            nop_cycle <= 1'b0;
            FLUSH_NOP <= 1'b0;
        end else begin
            // INSTR is only looked at on the Q1 edge
            if (at_q1) begin
                if (flushing) begin
                    nop_cycle <= 1'b1;                                                  // [RQ2]
                    FLUSH_NOP <= 1'b1;                                                  // [RQ2]
                end else begin
                    nop_cycle <= 1'b0;
                    FLUSH_NOP <= 1'b0;
                    ir        <= INSTR;
                end
            end
        end
    end

    // Count of skipped words still to be replaced by no-operations
    always @* begin
        next_flush = flush_cnt;
        case (q)
            ST_Q1: begin
                if (flushing) begin
                    next_flush = flush_cnt - 2'h1;                                      // [RQ5]
                end
            end
            ST_Q4: begin
                if (skip_taken) begin
                    if (NEXT_TWO_WORD) begin
                        next_flush = `CSBD_FLUSH_TWO;                                   // [RQ5]
                    end else begin
                        next_flush = `CSBD_FLUSH_ONE;                                   // [RQ2] [RQ4]
                    end
                end
            end
            default: begin
                next_flush = flush_cnt;
            end
        endcase
    end

    // Flush counter register
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            flush_cnt <= 2'h0;
        end else begin
            flush_cnt <= next_flush;
        end
    end

    // Compare path: address at Q2, borrow at Q3, decision at Q4
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            less      <= 1'b0;
            FILE_ADDR <= `CSBD_RST_ADDR;
            FILE_RD   <= 1'b0;
            CMP_LESS  <= 1'b0;
        end else begin
            FILE_RD <= at_q2 && is_cmp_lt;
            if (at_q2 && is_cmp_lt) begin
                FILE_ADDR <= next_addr;                                                 // [RQ3]
            end
            // FILE_DATA must be valid by the Q3 edge
            if (at_q3 && is_cmp_lt) begin
                less <= diff[8];                                                        // [RQ1]
            end
            // Only the result flag moves; W, file and status flags stay as they are
            if (at_q4 && is_cmp_lt) begin
                CMP_LESS <= less;                                                       // [RQ7]
            end
        end
    end

    // Decimal adjust: latch the correction at Q3, write W and carry at Q4
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            daw_value <= `CSBD_RST_BYTE;
            daw_carry <= 1'b0;
            W_OUT     <= `CSBD_RST_BYTE;
            W_WE      <= 1'b0;
            C_OUT     <= 1'b0;
            C_WE      <= 1'b0;
        end else begin
            // Digit carry is never written back
            W_WE <= at_q4 && is_daw;
            C_WE <= at_q4 && is_daw;
            if (at_q3 && is_daw) begin
                daw_value <= bcd_value;                                                 // [RQ6]
                daw_carry <= bcd_carry;                                                 // [RQ6]
            end
            if (at_q4 && is_daw) begin
                W_OUT <= daw_value;                                                     // [RQ6]
                C_OUT <= daw_carry;                                                     // [RQ6]
            end
        end
    end

endmodule // csbd_exec

// File: inc/csbd_defines.vh
// Constants for the compare-skip and decimal-adjust execution block
// Function
// RQ1: Compare-skip subtracts working register from file byte, both unsigned 8-bit.
// RQ2: File byte below working register discards next fetched instruction, runs no-operation.
// RQ3: Bank bit 0 uses access bank; bank bit 1 uses bank select register.
// RQ4: Compare-skip is one word; one cycle, or two when skipping.
// RQ5: Skipping a two-word instruction costs three cycles, both words become no-operations.
// RQ6: Decimal adjust adds 6 to nibbles above 9 or carrying, giving packed BCD.
// RQ7: Compare-skip changes no flags and writes neither working nor file register.
`ifndef CSBD_DEFINES_VH
`define CSBD_DEFINES_VH

// Instruction encodings
`define CSBD_CMP_LT_MASK   16'hfe00
`define CSBD_CMP_LT_OPC    16'h6000
`define CSBD_DAW_OPC       16'h0007
`define CSBD_BANK_BIT      8

// Access bank split: low part maps to bank 0, high part to the top bank
`define CSBD_ACCESS_SPLIT  8'h80
`define CSBD_ACCESS_HIGH   4'hf
`define CSBD_ACCESS_LOW    4'h0

// Decimal adjust constants
`define CSBD_BCD_LIMIT     4'h9
`define CSBD_BCD_CORR      5'h06

// Quarter-cycle codes
`define CSBD_Q1            2'h0
`define CSBD_Q2            2'h1
`define CSBD_Q3            2'h2
`define CSBD_Q4            2'h3

// Flush counts after a taken skip
`define CSBD_FLUSH_ONE     2'h1
`define CSBD_FLUSH_TWO     2'h2

// Reset values
`define CSBD_RST_BYTE      8'h00
`define CSBD_RST_ADDR      12'h000
`define CSBD_RST_INSTR     16'h0000

`endif

// File: core/csbd_bcd_adjust.v
// Packed BCD correction of the working register after a binary add
`timescale 1ns/100ps
`include "csbd_defines.vh"

module csbd_bcd_adjust (
    input  wire [7:0] w_in,      // Working register before correction
    input  wire       carry_in,  // Carry flag from the add
    input  wire       dcarry_in, // Digit carry flag from the add
    output reg  [7:0] w_out,     // Corrected value
    output reg        carry_out  // New carry flag
);

    reg [4:0] low_sum;
    reg [4:0] high_sum;
    reg [4:0] high_base;
    reg       low_fix;
    reg       high_fix;

    always @* begin
        low_fix  = (w_in[3:0] > `CSBD_BCD_LIMIT) || dcarry_in;                          // [RQ6]
        low_sum  = {1'b0, w_in[3:0]} + (low_fix ? `CSBD_BCD_CORR : 5'h00);              // [RQ6]
        // High nibble is judged after the low nibble's carry has been added
        high_base = {1'b0, w_in[7:4]} + {4'h0, low_sum[4]};                             // [RQ6]
        high_fix  = (high_base > {1'b0, `CSBD_BCD_LIMIT}) || carry_in;                  // [RQ6]
        high_sum  = high_base + (high_fix ? `CSBD_BCD_CORR : 5'h00);                    // [RQ6]
        w_out     = {high_sum[3:0], low_sum[3:0]};
        carry_out = high_sum[4] || carry_in;
    end

endmodule // csbd_bcd_adjust

// File: sim/csbd_exec_chk.sv
// Port assertions for the compare-skip and decimal-adjust block
`timescale 1ns/100ps
module csbd_exec_chk (
    input wire       MCLK,      // Clock
    input wire       RST_N,     // Reset
    input wire [1:0] Q_PHASE,   // Quarter
    input wire       CYCLE_END, // Last quarter
    input wire       FILE_RD,   // Read strobe
    input wire       W_WE,      // W strobe
    input wire       C_WE,      // Carry strobe
    input wire       FLUSH_NOP, // Forced no-op
    input wire       CMP_LESS   // Compare result
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    phase_step_a: assert property ($past(RST_N) |-> Q_PHASE == 2'($past(Q_PHASE) + 2'h1))
        else $error("quarter did not advance");
    cycle_end_a: assert property (CYCLE_END == (Q_PHASE == 2'h3))
        else $error("cycle end out of place");
    read_pulse_a: assert property ($rose(FILE_RD) |-> Q_PHASE == 2'h2 ##1 !FILE_RD)
        else $error("read strobe misplaced");
    flush_start_a: assert property ($rose(FLUSH_NOP) |-> Q_PHASE == 2'h1 && CMP_LESS)
        else $error("flush without less result");
    flush_cycle_a: assert property ($rose(FLUSH_NOP) |-> FLUSH_NOP [*4])
        else $error("flush shorter than a cycle");
    flush_bound_a: assert property ($rose(FLUSH_NOP) |-> ##[4:8] !FLUSH_NOP)
        else $error("flush longer than two cycles");
    flush_quiet_a: assert property (FLUSH_NOP |-> !FILE_RD && !W_WE)
        else $error("activity in flushed cycle");
    cmp_no_write_a: assert property (FILE_RD |=> (!W_WE && !C_WE) [*4])
        else $error("compare wrote a register");
endmodule // csbd_exec_chk

bind csbd_exec csbd_exec_chk chk_u (
    .MCLK      (MCLK),
    .RST_N     (RST_N),
    .Q_PHASE   (Q_PHASE),
    .CYCLE_END (CYCLE_END),
    .FILE_RD   (FILE_RD),
    .W_WE      (W_WE),
    .C_WE      (C_WE),
    .FLUSH_NOP (FLUSH_NOP),
    .CMP_LESS  (CMP_LESS)
);

// File: sim/tb_csbd_exec.sv
// Self-checking bench for the compare-skip and decimal-adjust block
`timescale 1ns/100ps
module tb_csbd_exec;
    reg         MCLK = 1'b0;
    reg         RST_N = 1'b0;
    reg  [15:0] INSTR = 16'h0000;
    reg         NEXT_TWO_WORD = 1'b0;
    reg  [7:0]  W_IN = 8'h00;
    reg  [7:0]  FILE_DATA = 8'h00;
    reg  [3:0]  BANK_SEL = 4'h0;
    reg         C_IN = 1'b0;
    reg         DC_IN = 1'b0;
    wire [1:0]  Q_PHASE;
    wire        CYCLE_END, FILE_RD, W_WE, C_WE, C_OUT, FLUSH_NOP, CMP_LESS;
    wire [11:0] FILE_ADDR;
    wire [7:0]  W_OUT;
    integer     miscompares = 0;
    integer     check_count = 0;
    integer     i, k, m, n;
    csbd_exec dut_u (
        .MCLK          (MCLK),
        .RST_N         (RST_N),
        .INSTR         (INSTR),
        .NEXT_TWO_WORD (NEXT_TWO_WORD),
        .W_IN          (W_IN),
        .FILE_DATA     (FILE_DATA),
        .BANK_SEL      (BANK_SEL),
        .C_IN          (C_IN),
        .DC_IN         (DC_IN),
        .Q_PHASE       (Q_PHASE),
        .CYCLE_END     (CYCLE_END),
        .FILE_ADDR     (FILE_ADDR),
        .FILE_RD       (FILE_RD),
        .W_OUT         (W_OUT),
        .W_WE          (W_WE),
        .C_OUT         (C_OUT),
        .C_WE          (C_WE),
        .FLUSH_NOP     (FLUSH_NOP),
        .CMP_LESS      (CMP_LESS)
    );
    always #10 MCLK = ~MCLK;
    task check(input [11:0] got, input [11:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Ends on the edge that starts a new cycle
    task sync;
        while (Q_PHASE !== 2'h3) @(negedge MCLK);
        @(posedge MCLK);
    endtask
    task run_cmp(input a, input [3:0] b, input [7:0] f, fd, w, input two);
        n = (fd < w) ? (two ? 2 : 1) : 0;
        sync;
        INSTR <= {7'h30, a, f};
        BANK_SEL <= b;
        FILE_DATA <= fd;
        W_IN <= w;
        NEXT_TWO_WORD <= two;
        k = 0;
        m = 0;
        for (i = 0; i < 15; i = i + 1) begin
            @(posedge MCLK);
            // Skipped words carry a decimal adjust that must be ignored
            if (i % 4 == 3) INSTR <= ((i - 3) / 4 < n) ? 16'h0007 : 16'h0000;
            @(negedge MCLK);
            if (i == 1) check(FILE_ADDR, a ? {b, f} : {{4{f[7]}}, f});
            if (i == 1) check(FILE_RD, 1);
            if (i == 3) check(CMP_LESS, n > 0);
            if (i % 4 == 1 && i > 1) k = k + FLUSH_NOP;
            m = m + (W_WE | C_WE);
        end
        check(k, n);
        check(m, 0);
    endtask
    task run_daw(input [7:0] w, input c, dc);
        reg [4:0] lo;
        reg [4:0] hi;
        lo = (w[3:0] > 9 || dc) ? w[3:0] + 5'h06 : w[3:0];
        hi = w[7:4] + lo[4];
        hi = (hi > 9 || c) ? hi + 5'h06 : hi;
        sync;
        INSTR <= 16'h0007;
        W_IN <= w;
        C_IN <= c;
        DC_IN <= dc;
        m = 0;
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge MCLK);
            if (i == 3) INSTR <= 16'h0000;
            @(negedge MCLK);
            m = m + (W_WE & C_WE);
        end
        check(m, 1);
        check({W_OUT, C_OUT}, {hi[3:0], lo[3:0], hi[4] | c});
    endtask
    initial begin
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
        run_cmp(1'b1, 4'h3, 8'h20, 8'h10, 8'h11, 1'b0);
        run_cmp(1'b0, 4'h3, 8'h7f, 8'h7f, 8'h80, 1'b1);
        run_cmp(1'b0, 4'h5, 8'h80, 8'h80, 8'h7f, 1'b1);
        run_cmp(1'b1, 4'hc, 8'hff, 8'h42, 8'h42, 1'b0);
        run_daw(8'ha5, 1'b0, 1'b0);
        run_daw(8'hce, 1'b0, 1'b0);
        run_daw(8'h99, 1'b0, 1'b0);
        run_daw(8'h9a, 1'b0, 1'b0);
        run_daw(8'h00, 1'b0, 1'b1);
        run_daw(8'h12, 1'b1, 1'b0);
        run_cmp(1'b0, 4'h0, 8'h00, 8'hfe, 8'hff, 1'b0);
        stop_test;
    end
    initial begin
        #100000;
        miscompares = miscompares + 1;
        stop_test;
    end
endmodule // tb_csbd_exec
